/* rtl/flags_pkg.sv */
// package of register offsets, bit positions and states for the status flag block
package flags_pkg;
  localparam logic [12:0] CTRL_BYTE_ADDR = 13'h1FF8;
  localparam logic [12:0] CENTURY_DAY_ADDR = 13'h1FFC;
  localparam logic [12:0] DATE_FLAGS_ADDR = 13'h1FFD;
  localparam logic [12:0] YEAR_ADDR = 13'h1FFF;
  localparam int WRITE_BIT = 7;
  localparam int READ_BIT = 6;
  localparam int BL_CHECK_EN_BIT = 7;
  localparam int BL_FLAG_BIT = 6;
  localparam int CENT_EN_BIT = 5;
  localparam int CENT_FLAG_BIT = 4;
  localparam logic [7:0] YEAR_LAST = 8'h99;
  localparam logic [7:0] YEAR_FIRST = 8'h00;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [7:0] CENT_DAY_MASK = 8'h47;
  localparam logic [7:0] DATE_MASK = 8'h3F;
  typedef enum logic [1:0] {
    chk_idle_type_s, chk_wait_type_s, chk_done_type_s
  } check_state_type;
endpackage

/* rtl/check_if.sv */
// interface carrying battery check requests and results between modules
`timescale 1ns/10ps
interface check_if;
  logic start;
  logic busy;
  logic done;
  logic low;
  modport ctrl (output start, input busy, input done, input low);
  modport seq (input start, output busy, output done, output low);
endinterface

/* rtl/battery_check_seq.sv */
// battery comparator sampling sequencer
`timescale 1ns/10ps
module battery_check_seq (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic batt_below_sync,
  check_if.seq chk
);
  import flags_pkg::*;
  check_state_type state_r;
  logic low_r;
  logic done_r;
  assign chk.busy = (state_r != chk_idle_type_s);
  assign chk.done = done_r;
  assign chk.low = low_r;
  // one cycle of settling so comparator result is taken after request
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      state_r <= chk_idle_type_s;
      low_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      done_r <= 1'b0;
      unique case (state_r)
        chk_idle_type_s: if (chk.start) state_r <= chk_wait_type_s;
        chk_wait_type_s: begin
          low_r <= batt_below_sync;
          state_r <= chk_done_type_s;
        end
        chk_done_type_s: begin
          done_r <= 1'b1;
          state_r <= chk_idle_type_s;
        end
      endcase
    end
  end
endmodule // battery_check_seq

/* rtl/battery_century_flags.sv */
// battery-low and century flag logic behind the byte-wide sram bus
`timescale 1ns/10ps
module battery_century_flags (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic [12:0] addr,
  input wire logic chip_en_n,
  input wire logic write_en_n,
  input wire logic output_en_n,
  input wire logic [7:0] dq_in,
  output logic [7:0] dq_out,
  output logic dq_oe,
  input wire logic vcc_good,
  input wire logic osc_running,
  input wire logic day_rollover,
  input wire logic batt_below,
  output logic write_halt,
  output logic update_halt
);
  import flags_pkg::*;

  // ****************************************
  // input synchronisers
  // ****************************************
  logic [6:0] s1_r;
  logic [6:0] s2_r;
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      // both stages reset to the idle level of the strobes, so no false write follows reset
      s1_r <= 7'h07;
      s2_r <= 7'h07;
    end else begin
      s1_r <= {batt_below, day_rollover, osc_running, vcc_good,
               output_en_n, write_en_n, chip_en_n};
      s2_r <= s1_r;
    end
  end
  logic ce_n_s, we_n_s, oe_n_s, vcc_s, osc_s, roll_s, below_s;
  assign {below_s, roll_s, osc_s, vcc_s, oe_n_s, we_n_s, ce_n_s} = s2_r;

  logic [12:0] a1_r;
  logic [12:0] a2_r;
  logic [7:0] d1_r;
  logic [7:0] d2_r;
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      a1_r <= '0;
      a2_r <= '0;
      d1_r <= BYTE_ZERO;
      d2_r <= BYTE_ZERO;
    end else begin
      a1_r <= addr;
      a2_r <= a1_r;
      d1_r <= dq_in;
      d2_r <= d1_r;
    end
  end

  // ****************************************
  // bus write strobe
  // ****************************************
  logic wr_act_r;
  logic wr_act;
  logic wr_pulse;
  assign wr_act = !ce_n_s && !we_n_s;
  // commit on the trailing edge so address and data have settled
  assign wr_pulse = wr_act_r && !wr_act;
  logic [12:0] wa_r;
  logic [7:0] wd_r;
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      wr_act_r <= 1'b0;
      wa_r <= '0;
      wd_r <= BYTE_ZERO;
    end else begin
      wr_act_r <= wr_act;
      if (wr_act) begin
        wa_r <= a2_r;
        wd_r <= d2_r;
      end
    end
  end

  function automatic logic hit(input logic [12:0] a, input logic [12:0] target);
    return a == target;
  endfunction

  // ****************************************
  // control byte
  // ****************************************
  logic [7:0] ctrl_r;
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) ctrl_r <= BYTE_ZERO;
    else if (wr_pulse && hit(wa_r, CTRL_BYTE_ADDR)) ctrl_r <= wd_r;
  end
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      write_halt <= 1'b0;
      update_halt <= 1'b0;
    end else begin
      write_halt <= ctrl_r[WRITE_BIT];
      update_halt <= ctrl_r[WRITE_BIT] | ctrl_r[READ_BIT];
    end
  end

  // ****************************************
  // year tracking and century turn
  // ****************************************
  logic [7:0] year_r;
  logic [7:0] year_prev_r;
  logic cent_turn;
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      year_r <= BYTE_ZERO;
      year_prev_r <= BYTE_ZERO;
    end else begin
      if (wr_pulse && hit(wa_r, YEAR_ADDR)) year_r <= wd_r;
      year_prev_r <= year_r;
    end
  end
  // host year loads made under the write bit are not a turn
  assign cent_turn = (year_prev_r == YEAR_LAST) && (year_r == YEAR_FIRST)
                     && !ctrl_r[WRITE_BIT];

  // ****************************************
  // century / day byte
  // ****************************************
  logic [7:0] cday_r;
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) cday_r <= BYTE_ZERO;
    else begin
      if (wr_pulse && hit(wa_r, CENTURY_DAY_ADDR)) begin
        cday_r <= (cday_r & ~CENT_DAY_MASK) | (wd_r & CENT_DAY_MASK);
        cday_r[CENT_EN_BIT] <= wd_r[CENT_EN_BIT];
        if (ctrl_r[WRITE_BIT]) cday_r[CENT_FLAG_BIT] <= wd_r[CENT_FLAG_BIT];
      end
      if (cent_turn && cday_r[CENT_EN_BIT])
        cday_r[CENT_FLAG_BIT] <= ~cday_r[CENT_FLAG_BIT];
    end
  end

  // ****************************************
  // battery check scheduling
  // ****************************************
  check_if chk ();
  battery_check_seq u_seq (
    .core_clk(core_clk),
    .rstn(rstn),
    .batt_below_sync(below_s),
    .chk(chk)
  );
  logic roll_r;
  logic pu_pending_r;
  logic roll_pending_r;
  logic start_r;
  assign chk.start = start_r;
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      roll_r <= 1'b0;
      pu_pending_r <= 1'b1;
      roll_pending_r <= 1'b0;
      start_r <= 1'b0;
    end else begin
      roll_r <= roll_s;
      start_r <= 1'b0;
      if (!vcc_s) pu_pending_r <= 1'b1;
      if (roll_s && !roll_r && vcc_s && osc_s) roll_pending_r <= 1'b1;
      // no check in backup mode; power loss drops a queued daily check
      if (!vcc_s) roll_pending_r <= 1'b0;
      else if (osc_s && (pu_pending_r || roll_pending_r) && !chk.busy && !start_r) begin
        start_r <= 1'b1;
        pu_pending_r <= 1'b0;
        // a rollover edge in this same cycle stays queued: set wins over clear
        roll_pending_r <= roll_s && !roll_r && osc_s;
      end
    end
  end

  // ****************************************
  // date / flags byte
  // ****************************************
  logic [7:0] dflag_r;
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) dflag_r <= BYTE_ZERO;
    else begin
      if (wr_pulse && hit(wa_r, DATE_FLAGS_ADDR)) begin
        dflag_r <= (dflag_r & ~DATE_MASK) | (wd_r & DATE_MASK);
        dflag_r[BL_CHECK_EN_BIT] <= wd_r[BL_CHECK_EN_BIT];
      end
      // flag is read-only to the host; only a check moves it
      if (chk.done) begin
        if (chk.low && dflag_r[BL_CHECK_EN_BIT]) dflag_r[BL_FLAG_BIT] <= 1'b1;
        else if (!chk.low) dflag_r[BL_FLAG_BIT] <= 1'b0;
      end
    end
  end

  // ****************************************
  // read path
  // ****************************************
  logic [7:0] rd_data;
  always_comb begin
    rd_data = BYTE_ZERO;
    // unused bits of this byte are never written, so they always read zero
    if (hit(a2_r, CENTURY_DAY_ADDR)) rd_data = cday_r;
    else if (hit(a2_r, DATE_FLAGS_ADDR)) rd_data = dflag_r;
    else if (hit(a2_r, CTRL_BYTE_ADDR)) rd_data = ctrl_r;
    else if (hit(a2_r, YEAR_ADDR)) rd_data = year_r;
  end
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      dq_out <= BYTE_ZERO;
      dq_oe <= 1'b0;
    end else begin
      dq_out <= rd_data;
      dq_oe <= !ce_n_s && !oe_n_s && we_n_s;
    end
  end
endmodule // battery_century_flags

/* dv/flags_properties.sv */
// checker of the flag block port behaviour
`timescale 1ns/10ps
module flags_properties
  import flags_pkg::*;
(
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic [12:0] addr,
  input wire logic chip_en_n,
  input wire logic write_en_n,
  input wire logic output_en_n,
  input wire logic vcc_good,
  input wire logic [7:0] dq_out,
  input wire logic dq_oe,
  input wire logic write_halt,
  input wire logic update_halt
);
  // ****
  // properties
  // ****
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  halt_implies_update_a: assert property (write_halt |-> update_halt)
    else $error("halt pair wrong");
  halt_hold_a: assert property (chip_en_n [*6] |-> $stable(write_halt))
    else $error("halt moved idle");
  oe_drive_a: assert property ((!chip_en_n && !output_en_n && write_en_n) [*5] |-> dq_oe)
    else $error("no drive on read");
  oe_quiet_a: assert property (chip_en_n [*5] |-> !dq_oe)
    else $error("drive while idle");
  cent_zero_bits_a: assert property ((addr == CENTURY_DAY_ADDR) [*5] |-> dq_out[7:3] ==? 5'b0???0)
    else $error("zero bits set");
  flag_no_check_a: assert property ((addr == DATE_FLAGS_ADDR && !vcc_good) [*8]
    |-> $stable(dq_out[BL_FLAG_BIT]))
    else $error("check without supply");
  flag_gate_a: assert property ((addr == DATE_FLAGS_ADDR && !dq_out[BL_CHECK_EN_BIT]) [*8]
    |-> !$rose(dq_out[BL_FLAG_BIT]))
    else $error("flag rose disabled");
  cent_hold_a: assert property ((addr == CENTURY_DAY_ADDR && write_en_n && !dq_out[CENT_EN_BIT]) [*8]
    |-> $stable(dq_out[CENT_FLAG_BIT]))
    else $error("century moved");
endmodule // flags_properties
bind battery_century_flags flags_properties flags_properties_inst (.core_clk, .rstn, .addr,
  .chip_en_n, .write_en_n, .output_en_n, .vcc_good, .dq_out, .dq_oe, .write_halt, .update_halt);

/* dv/host_model.sv */
// host processor model on the byte-wide sram bus
`timescale 1ns/10ps
module host_model (
  input wire logic core_clk,
  output logic [12:0] addr,
  output logic chip_en_n,
  output logic write_en_n,
  output logic output_en_n,
  output logic [7:0] dq_in,
  input wire logic [7:0] dq_out,
  input wire logic dq_oe
);
  // ****
  // bus cycles
  // ****
  initial begin
    addr = 13'h0000;
    chip_en_n = 1'b1;
    write_en_n = 1'b1;
    output_en_n = 1'b1;
    dq_in = 8'h00;
  end
  // century flag writes take effect only while the write bit is set
  task automatic wr(input logic [12:0] a, input logic [7:0] d);
    @(negedge core_clk);
    addr = a;
    dq_in = d;
    chip_en_n = 1'b0;
    write_en_n = 1'b0;
    repeat (4) @(negedge core_clk);
    chip_en_n = 1'b1;
    write_en_n = 1'b1;
    // released data lines show the inverse, never a stale copy
    dq_in = ~d;
    repeat (4) @(negedge core_clk);
  endtask
  task automatic rd(input logic [12:0] a, output logic [7:0] d);
    @(negedge core_clk);
    addr = a;
    chip_en_n = 1'b0;
    output_en_n = 1'b0;
    repeat (10) @(negedge core_clk);
    d = dq_oe ? dq_out : 8'hXX;
    chip_en_n = 1'b1;
    output_en_n = 1'b1;
    repeat (3) @(negedge core_clk);
  endtask
endmodule // host_model

/* dv/testbench.sv */
// self-checking bench of the battery-low and century flag block
`timescale 1ns/10ps
module testbench;
  import flags_pkg::*;
  typedef struct {logic [12:0] a; logic [7:0] w; logic [7:0] e; logic h;} row_type;
  row_type rows [6];
  logic core_clk, rstn, vcc_good, osc_running, day_rollover, batt_below;
  logic chip_en_n, write_en_n, output_en_n, dq_oe, write_halt, update_halt;
  logic [12:0] addr;
  logic [7:0] dq_in, dq_out, rd_val;
  int err_count = 0;
  int cmp_count = 0;
  battery_century_flags battery_century_flags_inst (.core_clk, .rstn, .addr, .chip_en_n,
    .write_en_n, .output_en_n, .dq_in, .dq_out, .dq_oe, .vcc_good, .osc_running,
    .day_rollover, .batt_below, .write_halt, .update_halt);
  host_model host_model_inst (.core_clk, .addr, .chip_en_n, .write_en_n, .output_en_n,
    .dq_in, .dq_out, .dq_oe);
  // ****
  // helpers
  // ****
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic roll();
    @(negedge core_clk);
    day_rollover = 1'b1;
    repeat (4) @(negedge core_clk);
    day_rollover = 1'b0;
    repeat (12) @(negedge core_clk);
  endtask
  task automatic results();
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  initial begin
    repeat (20000) @(posedge core_clk);
    err_count++;
    results();
  end
  // ****
  // tests
  // ****
  initial begin
    rstn = 1'b0;
    vcc_good = 1'b1;
    osc_running = 1'b1;
    day_rollover = 1'b0;
    batt_below = 1'b0;
    rows = '{'{DATE_FLAGS_ADDR, 8'hFF, 8'hBF, 0}, '{CENTURY_DAY_ADDR, 8'hFF, 8'h67, 0},
      '{CTRL_BYTE_ADDR, 8'h80, 8'h80, 1}, '{CENTURY_DAY_ADDR, 8'h10, 8'h10, 1},
      '{CTRL_BYTE_ADDR, 8'h00, 8'h00, 0}, '{13'h1000, 8'h5A, 8'h00, 0}};
    repeat (4) @(negedge core_clk);
    chk(dq_out | {5'h00, update_halt, dq_oe, write_halt}, 8'h00);
    rstn = 1'b1;
    repeat (12) @(negedge core_clk);
    $display("reset test done");
    foreach (rows[i]) begin
      host_model_inst.wr(rows[i].a, rows[i].w);
      chk({6'h00, update_halt, write_halt}, {6'h00, rows[i].h, rows[i].h});
      host_model_inst.rd(rows[i].a, rd_val);
      chk(rd_val, rows[i].e);
    end
    host_model_inst.wr(CTRL_BYTE_ADDR, 8'h40);
    chk({6'h00, update_halt, write_halt}, 8'h02);
    host_model_inst.wr(CTRL_BYTE_ADDR, 8'h00);
    chk({6'h00, update_halt, write_halt}, 8'h00);
    $display("table test done");
    batt_below = 1'b1;
    roll();
    host_model_inst.rd(DATE_FLAGS_ADDR, rd_val);
    chk(rd_val, 8'hFF);
    vcc_good = 1'b0;
    batt_below = 1'b0;
    roll();
    host_model_inst.rd(DATE_FLAGS_ADDR, rd_val);
    chk(rd_val, 8'hFF);
    vcc_good = 1'b1;
    repeat (12) @(negedge core_clk);
    host_model_inst.rd(DATE_FLAGS_ADDR, rd_val);
    chk(rd_val, 8'hBF);
    // stopped oscillator: a rollover must not start a check
    osc_running = 1'b0;
    batt_below = 1'b1;
    roll();
    host_model_inst.rd(DATE_FLAGS_ADDR, rd_val);
    chk(rd_val, 8'hBF);
    osc_running = 1'b1;
    repeat (12) @(negedge core_clk);
    host_model_inst.rd(DATE_FLAGS_ADDR, rd_val);
    chk(rd_val, 8'hBF);
    host_model_inst.wr(DATE_FLAGS_ADDR, 8'h3F);
    batt_below = 1'b1;
    roll();
    host_model_inst.rd(DATE_FLAGS_ADDR, rd_val);
    chk(rd_val, 8'h3F);
    $display("battery test done");
    for (int k = 0; k < 3; k++) begin
      if (k == 1) begin
        host_model_inst.wr(CTRL_BYTE_ADDR, 8'h80);
        host_model_inst.wr(CENTURY_DAY_ADDR, 8'h30);
        host_model_inst.wr(CTRL_BYTE_ADDR, 8'h00);
      end
      host_model_inst.wr(YEAR_ADDR, YEAR_LAST);
      host_model_inst.wr(YEAR_ADDR, YEAR_FIRST);
      host_model_inst.rd(CENTURY_DAY_ADDR, rd_val);
      chk(rd_val, k == 0 ? 8'h10 : (k == 1 ? 8'h20 : 8'h30));
    end
    $display("century test done");
    results();
  end
endmodule // testbench
